/* bench/daisy_slave_model.sv */
// daisy-chain slave model feeding the master's serial inputs
`timescale 1ns/10ps
module daisy_slave_model (
	input  wire       pol_i,
	output reg        sck_o,
	output reg  [2:0] bits_o
);
	// ****
	// word sender, clock still between frames
	// ****
	initial begin
		sck_o = 1'h0;
		bits_o = 3'h0;
	end
	task send(input [15:0] a, input [15:0] b);
		integer k;
		begin
			#1;
			sck_o = pol_i;
			#80;
			for (k = 15; k >= 0; k = k - 1) begin
				sck_o = ~pol_i; // launch edge
				bits_o = {k == 15, b[k], a[k]}; // strobe on msb
				#80;
				sck_o = pol_i; // master capture edge
				#80;
			end
			// data bits inverted and strobe dropped, so no stale data follows the frame
			bits_o = {1'h0, ~bits_o[1:0]};
		end
	endtask
endmodule

/* bench/ddc_output_port_tb_top.sv */
// self-checking bench for the downconverter output and control port
`timescale 1ns/10ps
module ddc_output_port_tb_top;
	// ****
	// signals, clock and tasks
	// ****
	reg         sys_clk_i = 1'h0, rst_n_i = 1'h0, clk_en_i = 1'h1;
	reg [15:0]  sample_a_i = 16'h0000, sample_b_i = 16'h0000;
	reg         sample_valid_i = 1'h0, debug_mode_i = 1'h0;
	reg [127:0] parallel_words_i = 128'h8F07_7E06_6D05_5C04_4B03_3A02_2901_1800;
	reg [19:0]  debug_word_i = 20'hB3E68;
	reg         serial_output_enable_i = 1'h0, serial_clock_polarity_i = 1'h0;
	reg         pair_packing_i = 1'h0, strobe_polarity_i = 1'h0;
	reg         ready_polarity_i = 1'h0, daisy_master_i = 1'h0;
	reg         sample_period_i = 1'h0, sync_n_i = 1'h1;
	reg         parallel_out_enable_n_i = 1'h1, chip_select_n_i = 1'h1;
	reg         read_n_i = 1'h1, write_n_i = 1'h1;
	reg [7:0]   addr_i = 8'h00, ctl_data_i = 8'h00;
	reg [2:0]   sel = 3'h0;
	reg [15:0]  got_a, got_b, n_strb;
	reg [31:0]  sa, sb;
	wire [2:0]  slave_bits;
	wire        daisy_clock_i;
	wire [2:0]  parallel_word_select_i = daisy_master_i ? slave_bits : sel;
	wire [7:0]  ctl_data_o;
	wire [63:0] ctl_regs_o;
	wire [15:0] parallel_out_word_o, slave_word_a_o, slave_word_b_o;
	wire        sample_ready_o, ctl_data_oe_n_o, parallel_out_oe_n_o;
	wire        serial_out_a_o, serial_out_b_o, serial_clock_o, serial_oe_n_o;
	wire        serial_word_strobe_o, serial_word_strobe_oe_n_o;
	wire        output_sample_period_o, gain_strobe_a_o, gain_strobe_b_o;
	wire        sync_pulse_o, flush_o, slave_word_valid_o;
	integer     err_count = 0, n_checks = 0, cyc = 0, got_n = 0, i, n, p;
	ddc_output_port u_ddc_output_port (.*);
	daisy_slave_model u_daisy_slave_model (
		.pol_i (serial_clock_polarity_i),
		.sck_o (daisy_clock_i),
		.bits_o(slave_bits)
	);
	always #2 sys_clk_i = ~sys_clk_i;
	// words are caught here since the valid pulse lasts one cycle
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (slave_word_valid_o === 1'h1) begin
			got_a <= slave_word_a_o;
			got_b <= slave_word_b_o;
			got_n <= got_n + 1;
		end
		if (cyc == 8000) begin
			err_count = err_count + 1;
			close_out;
		end
	end
	task tick(input integer k);
		repeat (k) @(posedge sys_clk_i);
	endtask
	// capture edge of the serial output for the given clock polarity
	task edge_wait(input pol);
		begin
			if (pol)
				@(posedge serial_clock_o);
			else
				@(negedge serial_clock_o);
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		begin
			addr_i <= a;
			ctl_data_i <= d;
			chip_select_n_i <= 1'h0;
			write_n_i <= 1'h0;
			tick(4);
			chip_select_n_i <= 1'h1;
			write_n_i <= 1'h1;
			tick(2);
		end
	endtask
	task rd_reg(input [7:0] a, input [7:0] e);
		begin
			addr_i <= a;
			chip_select_n_i <= 1'h0;
			read_n_i <= 1'h0;
			tick(5);
			chk(ctl_data_o, e);
			chk(ctl_data_oe_n_o, 1'h0);
			chip_select_n_i <= 1'h1;
			read_n_i <= 1'h1;
			tick(1);
		end
	endtask
	task close_out;
		begin
			if (err_count == 0 && n_checks > 0) begin
				$display("RESULT: PASS");
			end else begin
				$display("RESULT: FAIL");
			end
			$finish;
		end
	endtask
	initial begin
		tick(6);
		rst_n_i <= 1'h1;
		tick(3);
		chk({serial_oe_n_o, serial_word_strobe_oe_n_o}, 16'h3);
		for (i = 0; i < 8; i = i + 1)
			rd_reg(i[7:0], 8'h00);
		for (i = 0; i < 8; i = i + 1)
			wr_reg(i[7:0], 8'hA0 + i[7:0]);
		for (i = 0; i < 8; i = i + 1)
			rd_reg(i[7:0], 8'hA0 + i[7:0]);
		rd_reg(8'hF3, 8'h00);
		chk(ctl_regs_o[63:48], 16'hA7A6);
		parallel_out_enable_n_i <= 1'h0;
		for (i = 0; i < 8; i = i + 1) begin
			sel <= i[2:0];
			tick(6);
			chk(parallel_out_word_o, parallel_words_i[i*16 +: 16]);
			chk(parallel_out_oe_n_o, 1'h0);
		end
		parallel_out_enable_n_i <= 1'h1;
		debug_mode_i <= 1'h1;
		tick(6);
		chk(parallel_out_word_o, debug_word_i[19:4]);
		chk({serial_word_strobe_o, output_sample_period_o}, 16'h1);
		chk(parallel_out_oe_n_o, 1'h0);
		debug_mode_i <= 1'h0;
		tick(6);
		chk(parallel_out_oe_n_o, 1'h1);
		for (i = 0; i < 4; i = i + 1) begin
			ready_polarity_i <= i[1];
			sample_period_i <= i[0];
			tick(3);
			chk(output_sample_period_o, i[0] ^ i[1]);
		end
		sample_valid_i <= 1'h1;
		tick(40);
		sample_valid_i <= 1'h0;
		chk(sample_ready_o, 1'h0);
		sync_n_i <= 1'h0;
		tick(6);
		chk({gain_strobe_a_o, gain_strobe_b_o}, 16'h0);
		chk({sample_ready_o, sync_pulse_o, flush_o}, 16'h7);
		sync_n_i <= 1'h1;
		tick(6);
		chk({gain_strobe_a_o, gain_strobe_b_o, sync_pulse_o, flush_o},
			16'hC);
		serial_output_enable_i <= 1'h1;
		tick(1);
		chk({serial_oe_n_o, serial_word_strobe_oe_n_o}, 16'h0);
		// second pass inverts clock and strobe and packs I/Q pairs
		for (p = 0; p < 2; p = p + 1) begin
			pair_packing_i <= p[0];
			strobe_polarity_i <= p[0];
			serial_clock_polarity_i <= p[0];
			sample_a_i <= 16'hC35A;
			sample_b_i <= 16'h1E87;
			sample_valid_i <= 1'h1;
			tick(1);
			sample_a_i <= 16'h5AC3;
			sample_b_i <= 16'h871E;
			tick(1);
			sample_valid_i <= 1'h0;
			n_strb = 16'h0000;
			for (n = 0; n < 400 &&
				(serial_word_strobe_o ^ p[0]) !== 1'h1; n = n + 1)
				edge_wait(p[0]);
			for (n = 0; n < 32; n = n + 1) begin
				sa = {sa[30:0], serial_out_a_o};
				sb = {sb[30:0], serial_out_b_o};
				n_strb = n_strb + {15'h0, serial_word_strobe_o ^ p[0]};
				edge_wait(p[0]);
			end
			chk(sa[31:16], 16'hC35A);
			chk(sa[15:0], 16'h5AC3);
			chk(sb[31:16], 16'h1E87);
			chk(sb[15:0], 16'h871E);
			chk(n_strb, p[0] ? 16'h0001 : 16'h0002);
		end
		strobe_polarity_i <= 1'h0;
		daisy_master_i <= 1'h1;
		for (i = 0; i < 2; i = i + 1) begin
			serial_clock_polarity_i <= i[0];
			tick(4);
			u_daisy_slave_model.send(16'hA5C3 ^ i[15:0], 16'h3C96 ^ i[15:0]);
			tick(20);
			chk(got_a, 16'hA5C3 ^ i[15:0]);
			chk(got_b, 16'h3C96 ^ i[15:0]);
			chk(got_n[15:0], i[15:0] + 16'h0001);
		end
		close_out;
	end
endmodule
bind ddc_output_port ddc_port_checker u_ddc_port_checker (.*);

/* bench/ddc_port_asserts.sv */
// concurrent checks on the downconverter output and control port
`timescale 1ns/10ps
module ddc_port_checker (
	input wire logic         sys_clk_i,
	input wire logic         rst_n_i,
	input wire logic         chip_select_n_i,
	input wire logic         read_n_i,
	input wire logic         write_n_i,
	input wire logic [7:0]   addr_i,
	input wire logic [7:0]   ctl_data_o,
	input wire logic         ctl_data_oe_n_o,
	input wire logic [63:0]  ctl_regs_o,
	input wire logic         serial_output_enable_i,
	input wire logic         serial_word_strobe_oe_n_o,
	input wire logic         debug_mode_i,
	input wire logic         sample_period_i,
	input wire logic         ready_polarity_i,
	input wire logic         output_sample_period_o,
	input wire logic         sync_n_i,
	input wire logic         gain_strobe_a_o,
	input wire logic         gain_strobe_b_o,
	input wire logic         parallel_out_enable_n_i,
	input wire logic [2:0]   parallel_word_select_i,
	input wire logic [127:0] parallel_words_i,
	input wire logic [15:0]  parallel_out_word_o,
	input wire logic         parallel_out_oe_n_o
);
	// ****
	// pin and bus relations
	// ****
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	bus_drive_a: assert property (
		ctl_data_oe_n_o == !(!chip_select_n_i && !read_n_i && write_n_i))
		else $error("data bus drive wrong");
	strobe_float_a: assert property (
		serial_word_strobe_oe_n_o == !serial_output_enable_i)
		else $error("word strobe enable wrong");
	ready_flag_a: assert property (
		(!debug_mode_i)[*3] |-> output_sample_period_o ==
		$past(sample_period_i ^ ready_polarity_i))
		else $error("ready flag wrong");
	gain_sync_a: assert property (
		(!sync_n_i)[*5] |-> !gain_strobe_a_o && !gain_strobe_b_o)
		else $error("gain strobes not held");
	par_float_a: assert property (
		(parallel_out_enable_n_i && !debug_mode_i)[*4] |-> parallel_out_oe_n_o)
		else $error("parallel pins driven");
	par_drive_a: assert property (
		(!parallel_out_enable_n_i)[*4] |-> !parallel_out_oe_n_o)
		else $error("parallel pins floating");
	par_word_a: assert property (
		(!parallel_out_enable_n_i && !debug_mode_i &&
		$stable(parallel_word_select_i))[*5] |-> parallel_out_word_o ==
		parallel_words_i[parallel_word_select_i*16 +: 16])
		else $error("parallel word wrong");
	ctl_read_a: assert property (
		(!chip_select_n_i && !read_n_i && write_n_i && $stable(addr_i))[*4]
		|-> ctl_data_o == ((addr_i < 8'h08) ?
		ctl_regs_o[addr_i[2:0]*8 +: 8] : 8'h00))
		else $error("read data wrong");
	cover property ((!sync_n_i)[*5]);
	cover property (debug_mode_i[*5]);
	cover property (!read_n_i && !chip_select_n_i);
endmodule

/* design/ddc_output_port.v */
// output framing, parallel port, sync and control bus of the downconverter
//
// Overview of operation
// - master captures slave bits on chosen edge
// - word strobe per word or I/Q pair
// - word strobe polarity, tristate until enabled
// - debug mode drives diagnostic bits out
// - select one of eight parallel words
// - drive parallel pins while enable low or in debug mode
// - master uses select pins as slave inputs
// - ready flag marks each sample period
// - ready flag driven regardless of enable
// - sync sampled on rising clock edge
// - sync clears bit count and word framing
// - sync flushes all held sample data
// - gain strobes held low during sync
// - eight bit two-way control data bus
// - drive data only on read cycle
// - each control register own address
// - read outputs addressed register contents
// - write loads addressed control register
// - serial data msb first on chosen edge
`timescale 1ns/10ps
`include "ddc_port_defs.vh"
module ddc_output_port (
	input  wire        sys_clk_i,
	input  wire        rst_n_i,
	input  wire        clk_en_i,
	input  wire [15:0] sample_a_i,
	input  wire [15:0] sample_b_i,
	input  wire        sample_valid_i,
	output wire        sample_ready_o,
	input  wire [127:0] parallel_words_i,
	input  wire [19:0] debug_word_i,
	input  wire        debug_mode_i,
	input  wire        serial_output_enable_i,
	input  wire        serial_clock_polarity_i,
	input  wire        pair_packing_i,
	input  wire        strobe_polarity_i,
	input  wire        ready_polarity_i,
	input  wire        daisy_master_i,
	input  wire        sample_period_i,
	input  wire        sync_n_i,
	input  wire        daisy_clock_i,
	input  wire [2:0]  parallel_word_select_i,
	input  wire        parallel_out_enable_n_i,
	input  wire        chip_select_n_i,
	input  wire        read_n_i,
	input  wire        write_n_i,
	input  wire [7:0]  addr_i,
	input  wire [7:0]  ctl_data_i,
	output reg  [7:0]  ctl_data_o,
	output wire        ctl_data_oe_n_o,
	output wire [63:0] ctl_regs_o,
	output reg  [15:0] parallel_out_word_o,
	output wire        parallel_out_oe_n_o,
	output reg         serial_out_a_o,
	output reg         serial_out_b_o,
	output reg         serial_clock_o,
	output wire        serial_oe_n_o,
	output reg         serial_word_strobe_o,
	output wire        serial_word_strobe_oe_n_o,
	output reg         output_sample_period_o,
	output reg         gain_strobe_a_o,
	output reg         gain_strobe_b_o,
	output reg         sync_pulse_o,
	output wire        flush_o,
	output reg  [15:0] slave_word_a_o,
	output reg  [15:0] slave_word_b_o,
	output reg         slave_word_valid_o
);
	// ************************************************
	// input synchronisers
	// ************************************************
	reg [1:0] sck_s;
	reg       sck_d;
	reg [2:0] sel_m;
	reg [2:0] sel_s;
	reg [1:0] sync_s;
	reg [1:0] oe_s;
	reg [1:0] cs_s;
	reg [1:0] rd_s;
	reg [1:0] wr_s;
	reg [7:0] addr_m;
	reg [7:0] addr_s;
	reg [7:0] din_m;
	reg [7:0] din_s;
	reg       wr_d;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_s  <= 2'h0;
			sck_d  <= 1'b0;
			sel_m  <= 3'h0;
			sel_s  <= 3'h0;
			sync_s <= 2'h3;
			oe_s   <= 2'h3;
			cs_s   <= 2'h3;
			rd_s   <= 2'h3;
			wr_s   <= 2'h3;
			addr_m <= 8'h00;
			addr_s <= 8'h00;
			din_m  <= 8'h00;
			din_s  <= 8'h00;
			wr_d   <= 1'b0;
		end else if (clk_en_i) begin
			sck_s  <= {sck_s[0], daisy_clock_i};
			sck_d  <= sck_s[1];
			sel_m  <= parallel_word_select_i;
			sel_s  <= sel_m;
			sync_s <= {sync_s[0], sync_n_i};
			oe_s   <= {oe_s[0], parallel_out_enable_n_i};
			cs_s   <= {cs_s[0], chip_select_n_i};
			rd_s   <= {rd_s[0], read_n_i};
			wr_s   <= {wr_s[0], write_n_i};
			addr_m <= addr_i;
			addr_s <= addr_m;
			din_m  <= ctl_data_i;
			din_s  <= din_m;
			wr_d   <= ~cs_s[1] & ~wr_s[1];
		end
	end
	wire sync_act = ~sync_s[1];
	// ************************************************
	// sync handling
	// ************************************************
	// a held sync keeps everything flushed, not only its first cycle
	assign flush_o = sync_act;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_pulse_o    <= 1'b0;
			gain_strobe_a_o <= 1'b1;
			gain_strobe_b_o <= 1'b1;
		end else if (clk_en_i) begin
			sync_pulse_o    <= sync_act;
			gain_strobe_a_o <= ~sync_act;
			gain_strobe_b_o <= ~sync_act;
		end
	end
	// ************************************************
	// control register file
	// ************************************************
	reg [7:0] ctl_reg [0:`CTL_REG_CNT-1];
	wire      wr_pulse = ~cs_s[1] & ~wr_s[1] & ~wr_d;
	genvar g;
	generate
		for (g = 0; g < `CTL_REG_CNT; g = g + 1) begin : regs
			always @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					ctl_reg[g] <= `CTL_RST_VAL;
				else if (clk_en_i && wr_pulse && addr_s == g)
					ctl_reg[g] <= din_s;
			end
			assign ctl_regs_o[g*8+7:g*8] = ctl_reg[g];
		end
	endgenerate
	// unmapped addresses read zero
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ctl_data_o <= 8'h00;
		else if (clk_en_i) begin
			if (addr_s < `CTL_REG_CNT)
				ctl_data_o <= ctl_reg[addr_s[2:0]];
			else
				ctl_data_o <= 8'h00;
		end
	end
	// pins used directly so the bus releases without sync delay
	assign ctl_data_oe_n_o = ~(~chip_select_n_i & ~read_n_i &
		write_n_i);
	// ************************************************
	// serial output path through the fifo
	// ************************************************
	wire [31:0] fifo_data;
	wire        fifo_valid;
	reg         fifo_take;
	sample_fifo #(
		.WIDTH (`SHIFT_W),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.clk_en_i    (clk_en_i),
		.in_data_i   ({sample_a_i, sample_b_i}),
		.in_valid_i  (sample_valid_i & ~sync_act),
		.in_ready_o  (sample_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_take),
		.flush_i     (sync_act)
	);
	reg [3:0]  div_cnt;
	reg        sck_int;
	reg [15:0] sh_a;
	reg [15:0] sh_b;
	reg [15:0] nx_a;
	reg [15:0] nx_b;
	reg        nx_full;
	reg [4:0]  bit_cnt;
	reg        busy;
	reg        half;
	reg        frame;
	wire       shift_edge = (div_cnt == `SCK_DIV - 4'h1) & ~sck_int;
	// serial clock runs free; data moves on its rising internal phase
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= 4'h0;
			sck_int <= 1'b0;
			sh_a    <= 16'h0000;
			sh_b    <= 16'h0000;
			bit_cnt <= 5'h00;
			busy    <= 1'b0;
			half    <= 1'b0;
			frame   <= 1'b0;
			fifo_take <= 1'b0;
		end else if (clk_en_i) begin
			fifo_take <= 1'b0;
			if (div_cnt == `SCK_DIV - 4'h1) begin
				div_cnt <= 4'h0;
				sck_int <= ~sck_int;
			end else
				div_cnt <= div_cnt + 4'h1;
			if (sync_act) begin
				busy    <= 1'b0;
				frame   <= 1'b0;
				half    <= 1'b0;
				bit_cnt <= 5'h00;
			end else if (shift_edge) begin
				frame <= 1'b0;
				if (busy && bit_cnt != `WORD_BITS - 1) begin
					bit_cnt <= bit_cnt + 5'h01;
					sh_a    <= {sh_a[14:0], 1'b0};
					sh_b    <= {sh_b[14:0], 1'b0};
				end else if (fifo_valid && !fifo_take) begin
					busy      <= 1'b1;
					bit_cnt   <= 5'h00;
					sh_a      <= fifo_data[31:16];
					sh_b      <= fifo_data[15:0];
					fifo_take <= 1'b1;
					half      <= ~half;
					frame     <= ~pair_packing_i | ~half;
				end else
					busy <= 1'b0;
			end
		end
	end
	// ************************************************
	// pin drivers with debug override
	// ************************************************
	assign serial_oe_n_o             = ~serial_output_enable_i;
	assign serial_word_strobe_oe_n_o = ~serial_output_enable_i;
	wire   [2:0] sel_use = debug_mode_i ? 3'h0 : sel_s;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_out_a_o         <= 1'b0;
			serial_out_b_o         <= 1'b0;
			serial_clock_o         <= 1'b0;
			serial_word_strobe_o   <= 1'b0;
			output_sample_period_o <= 1'b0;
			parallel_out_word_o    <= 16'h0000;
		end else if (clk_en_i) begin
			serial_clock_o <= sck_int ^ serial_clock_polarity_i;
			if (debug_mode_i) begin
				parallel_out_word_o    <= debug_word_i[19:4];
				serial_word_strobe_o   <= debug_word_i[2];
				output_sample_period_o <= debug_word_i[3];
				serial_out_a_o         <= debug_word_i[1];
				serial_out_b_o         <= debug_word_i[0];
			end else begin
				parallel_out_word_o <=
					parallel_words_i[sel_use*16 +: 16];
				serial_word_strobe_o <= frame ^ strobe_polarity_i;
				output_sample_period_o <= sample_period_i ^ ready_polarity_i;
				serial_out_a_o <= sh_a[15] & busy;
				serial_out_b_o <= sh_b[15] & busy;
			end
		end
	end
	// ignored in debug mode; enable high floats the pins
	assign parallel_out_oe_n_o = debug_mode_i ? 1'b0 :
		oe_s[1];
	// ************************************************
	// daisy-chain slave capture
	// ************************************************
	reg [15:0] cap_a;
	reg [15:0] cap_b;
	reg [4:0]  cap_cnt;
	wire cap_edge = serial_clock_polarity_i ? (sck_s[1] & ~sck_d) :
		(~sck_s[1] & sck_d);
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_a              <= 16'h0000;
			cap_b              <= 16'h0000;
			cap_cnt            <= 5'h00;
			slave_word_a_o     <= 16'h0000;
			slave_word_b_o     <= 16'h0000;
			slave_word_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			slave_word_valid_o <= 1'b0;
			if (daisy_master_i && cap_edge) begin
				// strobe bit restarts the word count
				cap_a <= {cap_a[14:0], sel_s[0]};
				cap_b <= {cap_b[14:0], sel_s[1]};
				if (sel_s[2] ^ strobe_polarity_i)
					cap_cnt <= 5'h01;
				else if (cap_cnt == `WORD_BITS - 1) begin
					cap_cnt            <= 5'h00;
					slave_word_a_o     <= {cap_a[14:0], sel_s[0]};
					slave_word_b_o     <= {cap_b[14:0], sel_s[1]};
					slave_word_valid_o <= 1'b1;
				end else
					cap_cnt <= cap_cnt + 5'h01;
			end
		end
	end
endmodule

/* design/ddc_port_defs.vh */
// constants for the downconverter output and control port
`ifndef DDC_PORT_DEFS_VH
`define DDC_PORT_DEFS_VH
`define DATA_W        16
`define FIFO_DEPTH    32
`define FIFO_AW       5
`define WORD_BITS     16
`define BIT_CNT_W     5
`define SCK_DIV       4'h8
`define CTL_REG_CNT   8
`define CTL_RST_VAL   8'h00
`define DEBUG_W       20
`define SHIFT_W       32
`endif

/* design/sample_fifo.v */
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module sample_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             sys_clk_i,
	input  wire             rst_n_i,
	input  wire             clk_en_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i,
	input  wire             flush_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            full;
	wire            empty;
	wire            do_wr;
	wire            do_rd;
	assign full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
		(wr_ptr[AW] != rd_ptr[AW]);
	assign empty = (wr_ptr == rd_ptr);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	assign do_wr = in_valid_i & ~full;
	assign do_rd = out_ready_i & ~empty;
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else if (clk_en_i) begin
			if (flush_i) begin
				wr_ptr <= {(AW+1){1'b0}};
				rd_ptr <= {(AW+1){1'b0}};
			end else begin
				if (do_wr)
					wr_ptr <= wr_ptr + 1'b1;
				if (do_rd)
					rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
	always @(posedge sys_clk_i) begin
		if (clk_en_i && do_wr && !flush_i)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end
endmodule
